// [core/rtcsa_dev.sv]
`timescale 1ns/1ps
module rtcsa_dev
	import rtcsa_pkg::*;
#(
	parameter int NV_CYC = RTCSA_NV_WRITE_CYC,
	parameter int DEPTH = 256
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// two-wire link
	rtcsa_if.dev bus,
	// status and trims
	output logic nv_write_busy_latch,
	output logic [RTCSA_ADDR_W-1:0] addr_counter,
	output logic [RTCSA_DTRIM_W-1:0] digital_trim,
	output logic [RTCSA_ATRIM_W-1:0] analog_load_trim,
	output logic trim_skip_pulse,
	output logic trim_add_pulse
);
	// trims sit at low words and the index wraps by truncation, so depth must be a power of two
	if (NV_CYC < 1 || DEPTH < 32 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_param
		$error("rtcsa_dev: bad parameters");
	end
	localparam int AW = $clog2(DEPTH);
	logic [1:0] scl_s_r, sda_s_r;
	logic scl_d_r, sda_d_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[0], bus.scl};
			sda_s_r <= {sda_s_r[0], bus.sda};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end
	wire scl_i = scl_s_r[1];
	wire sda_i = sda_s_r[1];
	wire scl_rise = scl_i & ~scl_d_r;
	wire scl_fall = ~scl_i & scl_d_r;
	wire start_det = scl_i & scl_d_r & sda_d_r & ~sda_i;
	wire stop_det = scl_i & scl_d_r & ~sda_d_r & sda_i;

	// clock/control array contents; a write lands only when its stop arrives
	logic [7:0] mem [DEPTH];
	rtcsa_state_e st_r, st_nxt;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	logic [7:0] tx_r;
	logic ack_phase_r;
	logic ack_ok_r;
	logic [RTCSA_ADDR_W-1:0] cnt_r, wad_r;
	logic [7:0] wdat_r;
	logic wvalid_r;
	logic [31:0] nv_cnt_r;
	logic oe_r;
	logic slave_match_r;
	wire [7:0] sh_in = {sh_r[6:0], sda_i};
	wire slave_match = sh_in[7:1] == RTCSA_SLAVE_ID;
	wire [AW-1:0] cnt_idx = cnt_r[AW-1:0];

	function automatic logic [RTCSA_ADDR_W-1:0] inc_addr(input logic [RTCSA_ADDR_W-1:0] a);
		inc_addr = a + 16'h0001;
	endfunction : inc_addr

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r <= RTCSA_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			ack_phase_r <= 1'b0;
			ack_ok_r <= 1'b0;
			cnt_r <= RTCSA_ADDR_RST;
			wad_r <= RTCSA_ADDR_RST;
			wdat_r <= 8'h00;
			wvalid_r <= 1'b0;
			nv_cnt_r <= 32'h0;
			nv_write_busy_latch <= 1'b0;
			oe_r <= 1'b0;
			digital_trim <= RTCSA_DTRIM_RST;
			analog_load_trim <= RTCSA_ATRIM_RST;
		end else begin
			if (nv_write_busy_latch) begin
				if (nv_cnt_r == 32'h1) nv_write_busy_latch <= 1'b0;
				nv_cnt_r <= nv_cnt_r - 32'h1;
			end
			if (stop_det) begin
				oe_r <= 1'b0;
				ack_phase_r <= 1'b0;
				st_r <= RTCSA_IDLE;
				// only a fully acked data byte is committed
				if (st_r == RTCSA_WDAT && wvalid_r && !nv_write_busy_latch) begin
					mem[wad_r[AW-1:0]] <= wdat_r;
					if (wad_r == RTCSA_ATRIM_ADDR) analog_load_trim <= wdat_r[5:0];
					if (wad_r == RTCSA_DTRIM_ADDR) digital_trim <= wdat_r[2:0];
					nv_write_busy_latch <= 1'b1;
					nv_cnt_r <= NV_CYC;
				end
				wvalid_r <= 1'b0;
			end else if (start_det) begin
				st_r <= RTCSA_SLV;
				bit_r <= 4'h0;
				ack_phase_r <= 1'b0;
				oe_r <= 1'b0;
				wvalid_r <= 1'b0;
			end else if (st_r != RTCSA_IDLE && st_r != RTCSA_WAIT) begin
				if (scl_rise && !ack_phase_r && st_r != RTCSA_RDAT) begin
					sh_r <= sh_in;
					bit_r <= bit_r + 4'h1;
				end
				if (scl_rise && st_r == RTCSA_RDAT) begin
					if (ack_phase_r) begin
						ack_ok_r <= ~sda_i;
					end else begin
						bit_r <= bit_r + 4'h1;
					end
				end
				if (scl_fall) begin
					if (ack_phase_r) begin
						ack_phase_r <= 1'b0;
						bit_r <= 4'h0;
						oe_r <= 1'b0;
						if (st_r == RTCSA_RDAT) begin
							if (ack_ok_r) begin
								tx_r <= mem[cnt_idx];
								cnt_r <= inc_addr(cnt_r);
								oe_r <= ~mem[cnt_idx][7];
							end else begin
								st_r <= RTCSA_WAIT;
							end
						end else if (!ack_ok_r) begin
							st_r <= RTCSA_WAIT;
						end else if (st_r == RTCSA_SLV && sh_r[0]) begin
							st_r <= RTCSA_RDAT;
							tx_r <= mem[cnt_idx];
							cnt_r <= inc_addr(cnt_r);
							oe_r <= ~mem[cnt_idx][7];
						end else begin
							st_r <= st_nxt;
						end
					end else if (bit_r == 4'h8) begin
						ack_phase_r <= 1'b1;
						case (st_r)
							RTCSA_SLV: ack_ok_r <= slave_match_r;
							RTCSA_ADH: begin
								ack_ok_r <= 1'b1;
								wad_r[15:8] <= sh_r;
							end
							RTCSA_ADL: begin
								ack_ok_r <= 1'b1;
								wad_r[7:0] <= sh_r;
								cnt_r <= {wad_r[15:8], sh_r};
							end
							RTCSA_WDAT: begin
								ack_ok_r <= ~nv_write_busy_latch & ~wvalid_r;
								wdat_r <= sh_r;
								wvalid_r <= ~nv_write_busy_latch & ~wvalid_r;
							end
							RTCSA_RDAT: ack_ok_r <= 1'b0;
							default: ack_ok_r <= 1'b0;
						endcase
						oe_r <= (st_r == RTCSA_SLV) ? slave_match_r
							: (st_r == RTCSA_WDAT) ? (~nv_write_busy_latch & ~wvalid_r)
							: (st_r != RTCSA_RDAT);
					end else if (st_r == RTCSA_RDAT) begin
						tx_r <= {tx_r[6:0], 1'b0};
						oe_r <= ~tx_r[6] & (bit_r != 4'h8);
					end
				end
				if (scl_fall && !ack_phase_r && bit_r == 4'h8 && st_r == RTCSA_RDAT) begin
					oe_r <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) slave_match_r <= 1'b0;
		else if (scl_rise && bit_r == 4'h7) slave_match_r <= slave_match;
	end
	always_comb begin
		case (st_r)
			RTCSA_SLV: st_nxt = RTCSA_ADH;
			RTCSA_ADH: st_nxt = RTCSA_ADL;
			RTCSA_ADL: st_nxt = RTCSA_WDAT;
			RTCSA_WDAT: st_nxt = RTCSA_WDAT;
			default: st_nxt = RTCSA_IDLE;
		endcase
	end
	// digital trim: the last magnitude counts of each block carry a pulse, so rate scales per step
	logic [11:0] trim_cnt_r;
	wire [1:0] trim_mag = digital_trim[1:0];
	wire trim_tick = trim_cnt_r > (RTCSA_TRIM_LAST - {10'h000, trim_mag});
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trim_cnt_r <= 12'h000;
			trim_add_pulse <= 1'b0;
			trim_skip_pulse <= 1'b0;
		end else begin
			trim_cnt_r <= trim_cnt_r + 12'h001;
			trim_add_pulse <= trim_tick & ~digital_trim[2];
			trim_skip_pulse <= trim_tick & digital_trim[2];
		end
	end
	assign bus.sda_dev_o = 1'b0;
	assign bus.sda_dev_oe = oe_r;
	assign addr_counter = cnt_r;
endmodule : rtcsa_dev

// [core/rtcsa_host.sv]
`timescale 1ns/1ps
module rtcsa_host
	import rtcsa_pkg::*;
#(
	parameter int HALF = RTCSA_SCL_HALF_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// two-wire link
	rtcsa_if.host bus,
	// byte command: op 0 start+byte, 1 byte, 2 read byte, 3 stop
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ack,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_acked
);
	if (HALF < 4 || HALF > 65535) begin : g_bad_param
		$error("rtcsa_host: HALF out of range");
	end
	logic [1:0] sda_s_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) sda_s_r <= 2'h3;
		else sda_s_r <= {sda_s_r[0], bus.sda};
	end
	logic [15:0] div_r;
	wire tick = div_r == 16'(HALF - 1);
	logic busy_r, scl_r, sda_r;
	logic [5:0] ph_r;
	logic [1:0] op_r;
	logic [8:0] sh_r;
	logic [7:0] rx_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= 16'h0;
			busy_r <= 1'b0;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			ph_r <= 6'h0;
			op_r <= 2'h0;
			sh_r <= 9'h1ff;
			rx_r <= 8'h00;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_acked <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			div_r <= (tick || !busy_r) ? 16'h0 : div_r + 16'h1;
			if (!busy_r && cmd_valid) begin
				busy_r <= 1'b1;
				op_r <= cmd_op;
				ph_r <= 6'h0;
				// read byte ends with master ack or a released high nack
				sh_r <= (cmd_op == 2'h2) ? {8'hff, ~cmd_ack} : {cmd_data, 1'b1};
			end else if (busy_r && tick) begin
				ph_r <= ph_r + 6'h1;
				if (op_r == 2'h3) begin
					case (ph_r)
						6'h0: begin
							scl_r <= 1'b0;
							sda_r <= 1'b0;
						end
						6'h1: scl_r <= 1'b1;
						default: begin
							sda_r <= 1'b1;
							busy_r <= 1'b0;
						end
					endcase
				end else if (op_r == 2'h0 && ph_r < 6'h3) begin
					// start or repeated start ahead of the byte
					case (ph_r)
						6'h0: begin
							scl_r <= 1'b0;
							sda_r <= 1'b1;
						end
						6'h1: scl_r <= 1'b1;
						default: sda_r <= 1'b0;
					endcase
				end else begin
					if (!ph_r[0] ^ (op_r == 2'h0)) begin
						scl_r <= 1'b0;
						sda_r <= sh_r[8];
						sh_r <= {sh_r[7:0], 1'b1};
					end else begin
						scl_r <= 1'b1;
						rx_r <= {rx_r[6:0], sda_s_r[1]};
					end
					if (ph_r == ((op_r == 2'h0) ? 6'h14 : 6'h11)) begin
						busy_r <= 1'b0;
						rsp_valid <= 1'b1;
						rsp_data <= rx_r;
						rsp_acked <= ~sda_s_r[1];
					end
				end
			end
		end
	end
	assign cmd_ready = ~busy_r;
	assign bus.scl_o = scl_r;
	assign bus.sda_host_o = 1'b0;
	assign bus.sda_host_oe = ~sda_r;
endmodule : rtcsa_host

// [core/rtcsa_if.sv]
`timescale 1ns/1ps
interface rtcsa_if;
	logic scl_o;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda_host_o;
	logic sda_host_oe;
	wire scl = scl_o;
	wire sda = (sda_dev_oe & ~sda_dev_o) | (sda_host_oe & ~sda_host_o) ? 1'b0 : 1'b1;
	modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (output scl_o, input sda, output sda_host_o, output sda_host_oe);
endinterface : rtcsa_if

// [core/rtcsa_pkg.sv]
package rtcsa_pkg;
	localparam logic [6:0] RTCSA_SLAVE_ID = 7'h6f;
	localparam int RTCSA_ADDR_W = 16;
	localparam logic [15:0] RTCSA_ADDR_RST = 16'h0000;
	localparam int RTCSA_NV_WRITE_NS = 10000000;
	localparam int RTCSA_CLK_NS = 5;
	localparam int RTCSA_NV_WRITE_CYC = RTCSA_NV_WRITE_NS / RTCSA_CLK_NS;
	localparam int RTCSA_DTRIM_W = 3;
	localparam logic [2:0] RTCSA_DTRIM_RST = 3'h0;
	localparam int RTCSA_ATRIM_W = 6;
	localparam logic [5:0] RTCSA_ATRIM_RST = 6'h00;
	localparam int RTCSA_SCL_HALF_DIV = 32;
	localparam logic [15:0] RTCSA_DTRIM_ADDR = 16'h0010;
	localparam logic [15:0] RTCSA_ATRIM_ADDR = 16'h0011;
	localparam logic [11:0] RTCSA_TRIM_LAST = 12'hfff;
	typedef enum logic [3:0] {
		RTCSA_IDLE = 4'h0,
		RTCSA_SLV = 4'h1,
		RTCSA_ADH = 4'h2,
		RTCSA_ADL = 4'h3,
		RTCSA_WDAT = 4'h4,
		RTCSA_RDAT = 4'h5,
		RTCSA_RACK = 4'h6,
		RTCSA_WAIT = 4'h7
	} rtcsa_state_e;
endpackage : rtcsa_pkg

// [tb/rtc_serial_slave_access_tb.sv]
`timescale 1ns/1ps
module rtc_serial_slave_access_tb
	import rtcsa_pkg::*;
;
	localparam int NV = 3000;
	logic trim_add_pulse, trim_skip_pulse;
	int n_add, n_skip;
	logic clk, resetn, cmd_valid, cmd_ack, cmd_ready, rsp_valid, rsp_acked;
	logic nv_write_busy_latch;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data, rsp_data, dt, at;
	logic [15:0] addr_counter, base;
	logic [2:0] digital_trim;
	logic [5:0] analog_load_trim;
	// note: [9] data compared, [8] ack, [7:0] data
	logic [9:0] exp_q[$];
	logic [9:0] e;
	logic [7:0] mem [2];
	int n_mismatch = 0;
	int checks_done = 0;
	rtcsa_if bus_if();
	rtcsa_dev #(.NV_CYC(NV)) u_rtcsa_dev (.clk(clk), .resetn(resetn), .bus(bus_if),
		.nv_write_busy_latch(nv_write_busy_latch), .addr_counter(addr_counter),
		.digital_trim(digital_trim), .analog_load_trim(analog_load_trim),
		.trim_skip_pulse(trim_skip_pulse), .trim_add_pulse(trim_add_pulse));
	rtcsa_host #(.HALF(16)) u_rtcsa_host (.clk(clk), .resetn(resetn), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked));
	rtcsa_props #(.NV_CYC(NV)) u_props (.clk(clk), .resetn(resetn), .scl(bus_if.scl),
		.sda(bus_if.sda), .sda_dev_o(bus_if.sda_dev_o), .sda_dev_oe(bus_if.sda_dev_oe),
		.nv_write_busy_latch(nv_write_busy_latch));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	// ready is sampled one ns after the edge, so it is the value the next edge sees
	task automatic cmd(input logic [1:0] op, input logic [7:0] d, input logic ak,
		input logic [9:0] ex);
		@(posedge clk);
		#1;
		cmd_valid = 1;
		cmd_op = op;
		cmd_data = d;
		cmd_ack = ak;
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
		cmd_valid = 0;
		if (op != 2'h3)
			exp_q.push_back(ex);
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
	endtask : cmd
	task automatic addr_phase(input logic [15:0] a);
		cmd(2'h0, {RTCSA_SLAVE_ID, 1'b0}, 0, 10'h100);
		cmd(2'h1, a[15:8], 0, 10'h100);
		cmd(2'h1, a[7:0], 0, 10'h100);
	endtask : addr_phase
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic try_busy);
		addr_phase(a);
		cmd(2'h1, d, 0, 10'h100);
		cmd(2'h3, 8'h00, 0, 10'h000);
		repeat (4) @(posedge clk);
		check(nv_write_busy_latch, 1'b1);
		if (try_busy) begin
			addr_phase(a);
			cmd(2'h1, ~d, 0, 10'h000);
			cmd(2'h3, 8'h00, 0, 10'h000);
		end
		while (nv_write_busy_latch !== 1'b0)
			@(posedge clk);
		#1;
		check(nv_write_busy_latch, 1'b0);
	endtask : wr
	task automatic rd_cur(input int k, input int n);
		cmd(2'h0, {RTCSA_SLAVE_ID, 1'b1}, 0, 10'h100);
		for (int i = 0; i < n; i++)
			cmd(2'h2, 8'h00, i < n - 1, {1'b1, i < n - 1, mem[k + i]});
		cmd(2'h3, 8'h00, 0, 10'h000);
	endtask : rd_cur
	always @(negedge clk) begin
		if (rsp_valid === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 10'h3ff;
			check(rsp_acked, e[8]);
			if (e[9])
				check(rsp_data, e[7:0]);
		end
	end
	initial begin
		#400000;
		n_mismatch++;
		test_done();
	end
	initial begin
		{cmd_valid, cmd_op, cmd_data, cmd_ack, resetn} = 0;
		void'($urandom(32'h7356268e));
		repeat (8) @(posedge clk);
		#1 resetn = 1;
		base = 16'h0020 + 16'($urandom_range(0, 200));
		dt = 8'($urandom_range(1, 7));
		at = 8'($urandom_range(1, 63));
		mem[0] = 8'($urandom);
		mem[1] = 8'($urandom);
		check(addr_counter, RTCSA_ADDR_RST);
		wr(RTCSA_DTRIM_ADDR, dt, 0);
		wr(RTCSA_ATRIM_ADDR, at, 0);
		check(digital_trim, dt);
		check(analog_load_trim, at);
		// one full trim block holds exactly as many pulses as the step count
		n_add = 0;
		n_skip = 0;
		repeat (int'(RTCSA_TRIM_LAST) + 1) begin
			@(posedge clk);
			#1;
			n_add += int'(trim_add_pulse);
			n_skip += int'(trim_skip_pulse);
		end
		check(16'(n_add), dt[2] ? 16'h0000 : 16'(dt[1:0]));
		check(16'(n_skip), dt[2] ? 16'(dt[1:0]) : 16'h0000);
		wr(base, mem[0], 1);
		wr(base + 16'h1, mem[1], 0);
		addr_phase(base);
		cmd(2'h3, 8'h00, 0, 10'h000);
		repeat (20) @(posedge clk);
		check(nv_write_busy_latch, 1'b0);
		rd_cur(0, 2);
		check(addr_counter, base + 16'h2);
		addr_phase(base + 16'h1);
		rd_cur(1, 1);
		cmd(2'h0, {RTCSA_SLAVE_ID ^ 7'h01, 1'b1}, 0, 10'h000);
		cmd(2'h3, 8'h00, 0, 10'h000);
		repeat (50) @(posedge clk);
		check(16'(exp_q.size()), 16'h0);
		test_done();
	end
endmodule : rtc_serial_slave_access_tb

// [tb/rtcsa_props.sv]
`timescale 1ns/1ps
module rtcsa_props #(
	parameter int NV_CYC = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	// status
	input wire logic nv_write_busy_latch
);
	int busy_cnt_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			busy_cnt_r <= 0;
		else
			busy_cnt_r <= nv_write_busy_latch ? busy_cnt_r + 1 : 0;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_dev_pulls_low: assert property (sda_dev_oe |-> !sda_dev_o)
		else $error("device drove sda high");
	a_turn_scl_low: assert property ($changed(sda_dev_oe) |-> !scl)
		else $error("device changed sda with scl high");
	a_start_free: assert property (scl && $fell(sda) |-> !$past(sda_dev_oe))
		else $error("device held sda at a start");
	a_reset_quiet: assert property ($rose(resetn) |-> !sda_dev_oe)
		else $error("device drives sda after reset");
	a_drive_bounded: assert property ($rose(sda_dev_oe) |-> ##[1:700] !sda_dev_oe)
		else $error("device kept sda low too long");
	a_busy_at_idle: assert property ($rose(nv_write_busy_latch) |-> scl && sda)
		else $error("busy set while bus active");
	a_busy_holds: assert property ($rose(nv_write_busy_latch) |=> nv_write_busy_latch[*8])
		else $error("busy dropped early");
	a_busy_len: assert property ($fell(nv_write_busy_latch) |-> busy_cnt_r >= NV_CYC - 2)
		else $error("busy cycle too short");
	a_busy_max: assert property (busy_cnt_r <= NV_CYC + 2)
		else $error("busy cycle too long");
endmodule : rtcsa_props
